// ---- pkg/mouse_frontend_pkg.sv ----
// Constants, step codes and the quadrature decoder shared by the front end
`default_nettype none
package mouse_frontend_pkg;

	localparam int unsigned SYS_CLK_HZ   = 10_000_000;
	localparam int unsigned DEBOUNCE_MS  = 15;
	localparam int unsigned SAMPLE_US    = 100;
	localparam int unsigned DEBOUNCE_CYCLES_DEF =
		SYS_CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned SAMPLE_CYCLES =
		SYS_CLK_HZ / 1_000_000 * SAMPLE_US;

	localparam int unsigned BUTTON_COUNT = 3;
	localparam int unsigned DB_CNT_W     = 18;
	localparam int unsigned SAMPLE_CNT_W = 10;
	localparam int unsigned WHEEL_W      = 8;

	localparam logic [BUTTON_COUNT-1:0] BUTTONS_IDLE = 3'h7;
	localparam logic [1:0] PHASE_REST = 2'h3;

	localparam logic [1:0] STEP_NONE = 2'h0;
	localparam logic [1:0] STEP_UP   = 2'h1;
	localparam logic [1:0] STEP_DOWN = 2'h2;

	typedef enum logic [2:0]
	{
		PWR_OFF  = 3'h1,
		PWR_RUN  = 3'h2,
		PWR_SUSP = 3'h4
	} power_state_t;

	// Gray order 00,01,11,10 counts up; a jump of both phases is dropped
	function automatic logic [1:0] quad_step(input logic [1:0] prev,
		input logic [1:0] cur);
		logic [1:0] step;
		step = STEP_NONE;
		case ({prev, cur})
			4'h1, 4'h7, 4'hE, 4'h8: step = STEP_UP;
			4'h2, 4'hB, 4'hD, 4'h4: step = STEP_DOWN;
			default: step = STEP_NONE;
		endcase
		return step;
	endfunction

endpackage
`default_nettype wire

// ---- pkg/debounce_if.sv ----
// Carrier between the front end and its button filter
`timescale 1ns/1ps
`default_nettype none
interface debounce_if;
	logic [2:0] raw;
	logic [2:0] stable;
	modport filt (input raw, output stable);
	modport user (output raw, input stable);
endinterface
`default_nettype wire

// ---- rtl/button_debouncer.sv ----
// Chatter filter for the three button inputs
`timescale 1ns/1ps
`default_nettype none
module button_debouncer
	import mouse_frontend_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF
)
(
	input  wire logic  sys_clk,
	input  wire logic  rst_n,
	debounce_if.filt   dbg
);

	logic [DB_CNT_W-1:0] holdCnt [BUTTON_COUNT];
	logic [BUTTON_COUNT-1:0] expire;

	always_comb
	begin
		for (int i = 0; i < BUTTON_COUNT; i++)
			expire[i] = (holdCnt[i] == DB_CNT_W'(DEBOUNCE_CYCLES));
	end

	// Input is taken once the hold time has run from its first change,
	// whatever it did meanwhile
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dbg.stable <= BUTTONS_IDLE;
			for (int i = 0; i < BUTTON_COUNT; i++)
				holdCnt[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < BUTTON_COUNT; i++)
			begin
				if (holdCnt[i] == '0)
				begin
					if (dbg.raw[i] != dbg.stable[i])
						holdCnt[i] <= DB_CNT_W'(1);
				end
				else if (expire[i])
				begin
					dbg.stable[i] <= dbg.raw[i];
					holdCnt[i] <= '0;
				end
				else
					holdCnt[i] <= holdCnt[i] + DB_CNT_W'(1);
			end
		end
	end

	a_debounce_expiry: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(dbg.stable != $past(dbg.stable)) |-> ($past(expire) != '0))
		else $error("button value taken before hold time ran out");

	a_debounce_start: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(holdCnt[0] == '0 && dbg.raw[0] != dbg.stable[0])
		|=> (holdCnt[0] == DB_CNT_W'(1)) ##1 (dbg.stable[0] ==
		$past(dbg.stable[0])))
		else $error("left hold count did not start");

endmodule
`default_nettype wire

// ---- rtl/mouse_input_frontend.sv ----
// Button, scroll wheel and sensor power front end of the mouse controller
//
// Operation
// - A button change is accepted only once 15 ms have passed since its first edge.
// - Button inputs one, two and three report as left, middle and right.
// - Both wheel phases are sampled once every 100 us.
// - Mechanical variant enables phase pull-ups while operating only.
// - Optical variant never enables the phase pull-ups.
// - Sensor illumination drive is on while operating and off in suspend.
// - All timing counts derive from the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module mouse_input_frontend
	import mouse_frontend_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYCLES_DEF,
	parameter bit          MECHANICAL_WHEEL  = 1'b1
)
(
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               suspendReq,
	input  wire logic               left_button_in,
	input  wire logic               middle_button_in,
	input  wire logic               right_button_in,
	input  wire logic               scroll_phase_a,
	input  wire logic               scroll_phase_b,
	output logic [2:0]              buttonPressed,
	output logic                    scrollUp,
	output logic                    scrollDown,
	output logic [WHEEL_W-1:0]      wheelCount,
	output logic                    sensor_power_ctl,
	output logic                    illumDrive,
	output logic                    phasePullupEn,
	output logic                    operating
);

	debounce_if dbg ();

	power_state_t               powerState;
	power_state_t               next_powerState;
	logic [SAMPLE_CNT_W-1:0]    sampleCnt;
	logic                       sampleTick;
	logic [1:0]                 phaseSample;
	logic [1:0]                 phaseNow;
	logic [1:0]                 step;
	logic                       running;

	// Button order on the filter bus fixes the report bit order
	assign dbg.raw = {right_button_in, middle_button_in,
		left_button_in};

	button_debouncer #(
		.DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
	) u_debouncer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.dbg     (dbg)
	);

	// Buttons idle high through pull-ups, so pressed reads low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			buttonPressed <= '0;
		else
			buttonPressed <= ~dbg.stable;
	end

	// Power mode
	always_comb
	begin
		next_powerState = powerState;
		case (powerState)
			PWR_OFF:  next_powerState = suspendReq ? PWR_SUSP : PWR_RUN;
			PWR_RUN:  next_powerState = suspendReq ? PWR_SUSP : PWR_RUN;
			PWR_SUSP: next_powerState = suspendReq ? PWR_SUSP : PWR_RUN;
			default:  next_powerState = PWR_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			powerState <= PWR_OFF;
		else
			powerState <= next_powerState;
	end

	assign running = (powerState == PWR_RUN);
	assign operating = running;

	// Drives stay off through reset so the sensor never sees a glitch
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sensor_power_ctl <= 1'b0;
			illumDrive <= 1'b0;
		end
		else
		begin
			sensor_power_ctl <= (next_powerState == PWR_RUN);
			illumDrive <= (next_powerState == PWR_RUN);
		end
	end

	// Optical wheels carry their own drive; pulling up would load them
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			phasePullupEn <= 1'b0;
		else if (MECHANICAL_WHEEL)
			phasePullupEn <= (next_powerState == PWR_RUN);
		else
			phasePullupEn <= 1'b0;
	end

	// Sample interval timer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sampleCnt <= '0;
		else if (sampleTick)
			sampleCnt <= '0;
		else
			sampleCnt <= sampleCnt + SAMPLE_CNT_W'(1);
	end

	assign sampleTick =
		(sampleCnt == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));
	assign phaseNow = {scroll_phase_a, scroll_phase_b};
	assign step = quad_step(phaseSample, phaseNow);

	// Samples keep flowing in suspend so resume starts from a fresh
	// reference, but no step is reported there
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			phaseSample <= PHASE_REST;
		else if (sampleTick)
			phaseSample <= phaseNow;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scrollUp <= 1'b0;
			scrollDown <= 1'b0;
		end
		else
		begin
			scrollUp <= sampleTick && running
				&& (step == STEP_UP);
			scrollDown <= sampleTick && running
				&& (step == STEP_DOWN);
		end
	end

	// Wraps freely; the report logic takes differences
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wheelCount <= '0;
		else if (scrollUp)
			wheelCount <= wheelCount + WHEEL_W'(1);
		else if (scrollDown)
			wheelCount <= wheelCount - WHEEL_W'(1);
	end

	// Checking helpers
	logic [SAMPLE_CNT_W:0] tickGap;
	logic                  tickSeen;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickGap <= '0;
			tickSeen <= 1'b0;
		end
		else if (sampleTick)
		begin
			tickGap <= '0;
			tickSeen <= 1'b1;
		end
		else
			tickGap <= tickGap + (SAMPLE_CNT_W+1)'(1);
	end

	sequence s_run_tick;
		sampleTick && running;
	endsequence

	sequence s_fwd_step;
		s_run_tick ##0 (quad_step(phaseSample, phaseNow) == STEP_UP);
	endsequence

	sequence s_back_step;
		s_run_tick ##0 (quad_step(phaseSample, phaseNow) == STEP_DOWN);
	endsequence

	sequence s_double_jump;
		sampleTick ##0 ((phaseSample ^ phaseNow) == 2'h3);
	endsequence

	a_sample_spacing: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(sampleTick && tickSeen)
		|-> (tickGap == (SAMPLE_CNT_W+1)'(SAMPLE_CYCLES - 1)))
		else $error("wheel sample interval wrong");

	a_step_up: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		s_fwd_step |=> scrollUp && !scrollDown
		##1 (wheelCount == $past(wheelCount) + WHEEL_W'(1)))
		else $error("forward step not reported");

	a_step_down: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		s_back_step |=> scrollDown && !scrollUp)
		else $error("backward step not reported");

	a_double_ignored: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		s_double_jump |=> !scrollUp && !scrollDown)
		else $error("double phase jump counted");

	// Sampled rst_n skips the attempt at the edge that releases reset
	a_sensor_power: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		rst_n && suspendReq
		|=> !sensor_power_ctl && !illumDrive && !operating)
		else $error("sensor power on in suspend");

	a_illum_drive: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		rst_n && !suspendReq
		|=> illumDrive && sensor_power_ctl && operating)
		else $error("illumination off while operating");

	a_pullup_mech: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		MECHANICAL_WHEEL |-> (phasePullupEn == sensor_power_ctl))
		else $error("pull-up state does not follow mode");

	a_pullup_optical: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!MECHANICAL_WHEEL |-> !phasePullupEn)
		else $error("pull-up enabled on optical wheel");

	a_left_mapping: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		$changed(buttonPressed[0])
		|-> (buttonPressed[0] == !$past(left_button_in, 2)))
		else $error("left button reported from wrong input");

endmodule
`default_nettype wire

// ---- verif/mouse_far_side.sv ----
// Far-side model: three bouncing buttons and a quadrature scroll wheel
`timescale 1ns/1ps
`default_nettype none
module mouse_far_side
(
	input  wire logic sys_clk,
	output logic      leftRaw,
	output logic      middleRaw,
	output logic      rightRaw,
	output logic      phaseA,
	output logic      phaseB
);
	logic [1:0] gray [4];
	int         pos;

	initial
	begin
		gray = '{2'h0, 2'h1, 2'h3, 2'h2};
		pos = 2;
		{rightRaw, middleRaw, leftRaw} = 3'h7;
		{phaseA, phaseB} = 2'h3; // Wheel rests with equal phases
	end

	// Buttons pull low when pressed; bounces end on the pressed level
	task automatic press(input logic [2:0] mask, input int bounces);
		repeat (bounces)
		begin
			@(posedge sys_clk);
			{rightRaw, middleRaw, leftRaw} <= ~mask;
			@(posedge sys_clk);
			{rightRaw, middleRaw, leftRaw} <= 3'h7;
		end
		@(posedge sys_clk);
		{rightRaw, middleRaw, leftRaw} <= ~mask;
	endtask

	// One gray step per call; a delta of 2 jumps both phases at once
	task automatic turn(input int delta);
		pos = (pos + delta + 4) % 4;
		@(posedge sys_clk);
		{phaseA, phaseB} <= gray[pos];
	endtask
endmodule
`default_nettype wire

// ---- verif/mouse_input_frontend_tb.sv ----
// Self-checking bench for the mouse input front end
`timescale 1ns/1ps
`default_nettype none
module mouse_input_frontend_tb
	import mouse_frontend_pkg::*;
;
	localparam int unsigned DB = 20;
	logic               sys_clk;
	logic               rst_n;
	logic               suspendReq;
	logic               leftRaw, middleRaw, rightRaw, phaseA, phaseB;
	logic [2:0]         buttonPressed;
	logic               scrollUp, scrollDown, powerOn, illumOn;
	logic               pullupOn, pullupOpt, operating;
	logic [WHEEL_W-1:0] wheelCount;
	logic [WHEEL_W-1:0] expCount = '0;
	int                 mismatches = 0;
	int                 compares = 0;
	int                 n;

	mouse_input_frontend #(.DEBOUNCE_CYCLES(DB)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .suspendReq(suspendReq),
		.left_button_in(leftRaw), .middle_button_in(middleRaw),
		.right_button_in(rightRaw), .scroll_phase_a(phaseA),
		.scroll_phase_b(phaseB), .buttonPressed(buttonPressed),
		.scrollUp(scrollUp), .scrollDown(scrollDown),
		.wheelCount(wheelCount), .sensor_power_ctl(powerOn),
		.illumDrive(illumOn), .phasePullupEn(pullupOn),
		.operating(operating));
	// Optical variant shares the inputs; only its pull-up is watched
	mouse_input_frontend #(.DEBOUNCE_CYCLES(DB), .MECHANICAL_WHEEL(1'b0))
	DUT_OPT (
		.sys_clk(sys_clk), .rst_n(rst_n), .suspendReq(suspendReq),
		.left_button_in(leftRaw), .middle_button_in(middleRaw),
		.right_button_in(rightRaw), .scroll_phase_a(phaseA),
		.scroll_phase_b(phaseB), .buttonPressed(), .scrollUp(),
		.scrollDown(), .wheelCount(), .sensor_power_ctl(),
		.illumDrive(), .phasePullupEn(pullupOpt), .operating());
	mouse_far_side farSide (.sys_clk(sys_clk), .leftRaw(leftRaw),
		.middleRaw(middleRaw), .rightRaw(rightRaw), .phaseA(phaseA),
		.phaseB(phaseB));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	// Bounded wait for either scroll pulse; n equals lim when none came
	task automatic wait_pulse(input int lim);
		n = 0;
		while (n < lim && scrollUp !== 1'b1 && scrollDown !== 1'b1)
		begin
			tick(1);
			n++;
		end
	endtask

	task automatic t_buttons();
		for (int i = 0; i < 3; i++)
		begin
			farSide.press(3'h1 << i, 3);
			tick(10);
			chk(16'(buttonPressed), 16'h0000);
			tick(DB);
			chk(16'(buttonPressed), 16'(3'h1 << i));
			farSide.press(3'h0, 0);
			tick(DB + 5);
			chk(16'(buttonPressed), 16'h0000);
		end
	endtask

	task automatic t_wheel();
		for (int i = 0; i < 6; i++)
		begin
			farSide.turn(i < 3 ? 1 : -1);
			wait_pulse(1100);
			if (n == 1100)
			begin
				mismatches++;
				$display("[ERR] %0t no scroll pulse", $time);
				wrap_up();
			end
			chk({14'h0, scrollUp, scrollDown}, i < 3 ? 16'h2 : 16'h1);
			if (i > 0)
				chk(n[15:0], 16'(SAMPLE_CYCLES - 2));
			expCount = expCount + (i < 3 ? 8'h01 : 8'hFF);
			tick(1);
			chk(16'(wheelCount), 16'(expCount));
		end
		farSide.turn(2);
		wait_pulse(1100);
		chk(n[15:0], 16'd1100);
		chk(16'(wheelCount), 16'(expCount));
	endtask

	task automatic t_suspend();
		@(posedge sys_clk);
		suspendReq <= 1'b1;
		tick(2);
		chk({11'h0, powerOn, illumOn, pullupOn, operating, pullupOpt},
			16'h0000);
		farSide.turn(1);
		wait_pulse(1100);
		chk(n[15:0], 16'd1100);
		@(posedge sys_clk);
		suspendReq <= 1'b0;
		tick(2);
		chk({11'h0, powerOn, illumOn, pullupOn, operating, pullupOpt},
			16'h001E);
		wait_pulse(1100);
		chk(n[15:0], 16'd1100);
		chk(16'(wheelCount), 16'(expCount));
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial
	begin
		rst_n = 1'b0;
		suspendReq = 1'b0;
		tick(11);
		chk({11'h0, powerOn, illumOn, pullupOn, operating, pullupOpt},
			16'h0000);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		tick(3);
		chk({11'h0, powerOn, illumOn, pullupOn, operating, pullupOpt},
			16'h001E);
		t_buttons();
		t_wheel();
		t_suspend();
		wrap_up();
	end
endmodule
`default_nettype wire
